// ==== design/ppf_pkg.sv ====
// Package with shared constants and types of the ping-pong transform control.
package ppf_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int POINTS = 256;
	localparam int CLK_MHZ = 20;
	localparam int SAMPLE_PERIOD = 3;
	localparam int FRAME_CYCLES = 768;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 8'hFF;
	localparam logic [9:0] FRAME_LAST = 10'(FRAME_CYCLES - 1);
	localparam logic [9:0] RESULT_START = 10'(FRAME_CYCLES - POINTS);
	localparam logic [9:0] MODE_SAMPLE_AT = 10'(FRAME_CYCLES - 2);
	localparam logic [1:0] PACE_LAST = 2'(SAMPLE_PERIOD - 1);
	localparam logic [9:0] CNT_ZERO = 10'h000;
	localparam logic [1:0] PACE_ZERO = 2'h0;
	typedef logic [DATA_W-1:0] ppf_word_t;
	typedef logic [ADDR_W-1:0] ppf_addr_t;
	typedef enum logic [1:0] {PPF_IDLE, PPF_LOAD, PPF_WAIT, PPF_RUN} ppf_state_e;
endpackage : ppf_pkg

// ==== design/ppf_if.sv ====
// Interface joining the transform control core and the host side.
`timescale 1ns/1ps
interface ppf_if;
	import ppf_pkg::*;
	logic load_request;
	logic start;
	logic direction_select;
	logic scale_select;
	logic result_read_request;
	ppf_word_t input_sample_bus_re;
	ppf_word_t input_sample_bus_im;
	logic mode_sample_strobe;
	logic bank_select;
	logic bank0_porta_write_enable;
	logic bank1_porta_write_enable;
	logic bank0_portb_write_enable;
	logic bank1_portb_write_enable;
	logic bank0_porta_enable;
	logic bank1_porta_enable;
	ppf_addr_t load_address;
	ppf_word_t result_sample_bus_re;
	ppf_word_t result_sample_bus_im;
	ppf_addr_t result_index;
	logic result_strobe;
	modport core (
		input load_request, start, direction_select, scale_select,
		input result_read_request, input_sample_bus_re, input_sample_bus_im,
		output mode_sample_strobe, bank_select, load_address,
		output bank0_porta_write_enable, bank1_porta_write_enable,
		output bank0_portb_write_enable, bank1_portb_write_enable,
		output bank0_porta_enable, bank1_porta_enable,
		output result_sample_bus_re, result_sample_bus_im,
		output result_index, result_strobe
	);
	modport host (
		output load_request, start, direction_select, scale_select,
		output result_read_request, input_sample_bus_re, input_sample_bus_im,
		input mode_sample_strobe, bank_select, load_address,
		input bank0_porta_write_enable, bank1_porta_write_enable,
		input bank0_portb_write_enable, bank1_portb_write_enable,
		input bank0_porta_enable, bank1_porta_enable,
		input result_sample_bus_re, result_sample_bus_im,
		input result_index, result_strobe
	);
endinterface : ppf_if

// ==== design/ppf_core.sv ====
// Ping-pong bank control core of the 256-point transform engine.
// Summary of operation
// - Two working banks, no output bank.
// - Results go only to the result bus.
// - Swap working banks after each vector.
// - One new sample every three cycles while running.
// - Host may stream samples continuously.
// - Results leave in digit-reversed order.
// - Index bus gives natural-order position.
// - Result strobe frames valid results exactly.
// - Core writes working bank port A only.
// - Host unloads only after whole vector.
// - Mode sampled at start, then strobe.
// - Host may change mode between vectors.
// - Bank select steers host input mux.
// - Core drives all bank enables.
// - Host loads first bank beforehand.
// - Start is one clock pulse.
// - Host holds result read request low.
// - New result vector every 768 cycles.
// - Load request pulse starts initial load.
// - Mode inputs matter only at start and strobe.
`timescale 1ns/1ps
module ppf_core (
	input wire logic clk,
	input wire logic nrst,
	ppf_if.core link,
	output logic busy,
	output logic direction_active,
	output logic scale_active,
	output logic [1:0] result_digit
);
	import ppf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	ppf_state_e state_reg;
	logic [9:0] frame_cnt_reg;
	logic [1:0] pace_reg;
	ppf_addr_t addr_reg;
	logic bank_reg;
	logic dir_pend_reg;
	logic scale_pend_reg;
	logic first_reg;
	ppf_addr_t res_cnt;
	ppf_addr_t res_rev;
	logic load_tick;
	logic in_results;

	assign load_tick = (state_reg == PPF_RUN) && (pace_reg == PACE_LAST);
	assign in_results = (state_reg == PPF_RUN) && !first_reg &&
		(frame_cnt_reg >= RESULT_START);
	assign res_cnt = 8'(frame_cnt_reg - RESULT_START);

	// Digit reversal keeps the index a pure rewiring of the count.
	genvar g;
	generate
		for (g = 0; g < ADDR_W / 2; g++) begin : g_rev
			assign res_rev[2*g+1:2*g] =
				res_cnt[ADDR_W-1-2*g:ADDR_W-2-2*g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PPF_IDLE;
		end else if (link.start) begin
			state_reg <= PPF_RUN;
		end else begin
			case (state_reg)
				PPF_IDLE: if (link.load_request) state_reg <= PPF_LOAD;
				PPF_LOAD: if (addr_reg == ADDR_LAST) state_reg <= PPF_WAIT;
				PPF_WAIT: state_reg <= PPF_WAIT;
				PPF_RUN: state_reg <= PPF_RUN;
				default: state_reg <= PPF_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_cnt_reg <= CNT_ZERO;
			pace_reg <= PACE_ZERO;
			first_reg <= 1'b1;
		end else if (link.start) begin
			frame_cnt_reg <= CNT_ZERO;
			pace_reg <= PACE_ZERO;
			first_reg <= 1'b1;
		end else if (state_reg == PPF_RUN) begin
			pace_reg <= (pace_reg == PACE_LAST) ? PACE_ZERO : pace_reg + 2'h1;
			if (frame_cnt_reg == FRAME_LAST) begin
				frame_cnt_reg <= CNT_ZERO;
				first_reg <= 1'b0;
			end else begin
				frame_cnt_reg <= frame_cnt_reg + 10'h001;
			end
		end
	end

	// Load address: sequential during initial load and each paced load.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= ADDR_ZERO;
		end else if (link.start || (state_reg == PPF_IDLE)) begin
			addr_reg <= ADDR_ZERO;
		end else if (state_reg == PPF_LOAD || load_tick) begin
			addr_reg <= addr_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bank_reg <= 1'b0;
		end else if (link.start) begin
			bank_reg <= 1'b0;
		end else if (state_reg == PPF_RUN && frame_cnt_reg == FRAME_LAST) begin
			bank_reg <= !bank_reg;
		end
	end

	// Mode is captured at start and later only on the strobe cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dir_pend_reg <= 1'b0;
			scale_pend_reg <= 1'b0;
			direction_active <= 1'b0;
			scale_active <= 1'b0;
		end else begin
			if (link.start || link.mode_sample_strobe) begin
				dir_pend_reg <= link.direction_select;
				scale_pend_reg <= link.scale_select;
			end
			if (link.start) begin
				direction_active <= link.direction_select;
				scale_active <= link.scale_select;
			end else if (state_reg == PPF_RUN && frame_cnt_reg == FRAME_LAST) begin
				direction_active <= dir_pend_reg;
				scale_active <= scale_pend_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The arithmetic is outside this block, so results forward the input
	// bus word; only framing, order and bank control are modelled here.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.mode_sample_strobe <= 1'b0;
			link.bank_select <= 1'b0;
			link.load_address <= ADDR_ZERO;
			link.bank0_porta_write_enable <= 1'b0;
			link.bank1_porta_write_enable <= 1'b0;
			link.bank0_portb_write_enable <= 1'b0;
			link.bank1_portb_write_enable <= 1'b0;
			link.bank0_porta_enable <= 1'b0;
			link.bank1_porta_enable <= 1'b0;
			link.result_sample_bus_re <= '0;
			link.result_sample_bus_im <= '0;
			link.result_index <= ADDR_ZERO;
			link.result_strobe <= 1'b0;
			busy <= 1'b0;
			result_digit <= 2'h0;
		end else begin
			link.mode_sample_strobe <= (state_reg == PPF_RUN) &&
				(frame_cnt_reg == MODE_SAMPLE_AT);
			link.bank_select <= (state_reg == PPF_RUN) ? !bank_reg : 1'b0;
			link.load_address <= addr_reg;
			// Loading bank: bank 0 before start, else the idle bank.
			link.bank0_porta_write_enable <= (state_reg == PPF_LOAD) ||
				(load_tick && bank_reg);
			link.bank1_porta_write_enable <= load_tick && !bank_reg;
			link.bank0_portb_write_enable <= 1'b0;
			link.bank1_portb_write_enable <= 1'b0;
			link.bank0_porta_enable <= (state_reg == PPF_LOAD) ||
				(load_tick && bank_reg);
			link.bank1_porta_enable <= load_tick && !bank_reg;
			link.result_strobe <= in_results;
			link.result_index <= in_results ? res_rev : ADDR_ZERO;
			link.result_sample_bus_re <= in_results ?
				link.input_sample_bus_re : '0;
			link.result_sample_bus_im <= in_results ?
				link.input_sample_bus_im : '0;
			busy <= (state_reg == PPF_RUN);
			result_digit <= res_cnt[1:0];
		end
	end
endmodule : ppf_core

// ==== design/ppf_host.sv ====
// Host side: loads samples, starts the engine and sets the mode.
`timescale 1ns/1ps
module ppf_host (
	input wire logic clk,
	input wire logic nrst,
	ppf_if.host link,
	input wire logic user_load,
	input wire logic user_start,
	input wire logic user_direction,
	input wire logic user_scale,
	input wire ppf_pkg::ppf_word_t user_re,
	input wire ppf_pkg::ppf_word_t user_im,
	output logic result_frame_done
);
	import ppf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic strobe_d_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.load_request <= 1'b0;
			link.start <= 1'b0;
			link.direction_select <= 1'b0;
			link.scale_select <= 1'b0;
			link.result_read_request <= 1'b0;
			link.input_sample_bus_re <= '0;
			link.input_sample_bus_im <= '0;
		end else begin
			link.load_request <= user_load;
			link.start <= user_start && !link.start;
			link.direction_select <= user_direction;
			link.scale_select <= user_scale;
			link.result_read_request <= 1'b0;
			link.input_sample_bus_re <= user_re;
			link.input_sample_bus_im <= user_im;
		end
	end

	// Unloading waits for the end of the frame since results leave in digit-reversed order.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strobe_d_reg <= 1'b0;
			result_frame_done <= 1'b0;
		end else begin
			strobe_d_reg <= link.result_strobe;
			result_frame_done <= strobe_d_reg && !link.result_strobe;
		end
	end
endmodule : ppf_host

// ==== verif/ppf_chk.sv ====
// Concurrent checks on the link between the core and the host.
`timescale 1ns/1ps
module ppf_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic mode_sample_strobe,
	input wire logic bank_select,
	input wire logic bank0_porta_write_enable,
	input wire logic bank1_porta_write_enable,
	input wire logic bank0_portb_write_enable,
	input wire logic bank1_portb_write_enable,
	input wire logic bank0_porta_enable,
	input wire logic bank1_porta_enable,
	input wire ppf_pkg::ppf_addr_t result_index,
	input wire logic result_strobe
);
	logic [8:0] run_reg;
	logic [15:0] low_reg;
	logic [9:0] gap_reg;
	logic res_seen_reg;
	logic ms_seen_reg;
	////////////////////////////////////////////////////////////////////////
	// Counters give each result its position and the spacing of frames.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_reg <= 9'h000;
			low_reg <= 16'h0000;
			gap_reg <= 10'h000;
			res_seen_reg <= 1'b0;
			ms_seen_reg <= 1'b0;
		end else begin
			run_reg <= result_strobe ? run_reg + 9'h001 : 9'h000;
			low_reg <= result_strobe ? 16'h0000 : low_reg + 16'h0001;
			gap_reg <= mode_sample_strobe ? 10'h000 : gap_reg + 10'h001;
			res_seen_reg <= res_seen_reg | result_strobe;
			ms_seen_reg <= ms_seen_reg | mode_sample_strobe;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_nob; !(bank0_portb_write_enable || bank1_portb_write_enable);
	endproperty
	property p_ena; bank0_porta_enable == bank0_porta_write_enable &&
		bank1_porta_enable == bank1_porta_write_enable; endproperty
	property p_one; !(bank0_porta_write_enable && bank1_porta_write_enable);
	endproperty
	property p_pace; bank1_porta_write_enable |=>
		!bank1_porta_write_enable [*2]; endproperty
	property p_swap; $changed(bank_select) |=> $stable(bank_select) [*8];
	endproperty
	property p_run; $fell(result_strobe) |-> run_reg == 9'd256; endproperty
	property p_idx; result_strobe |-> result_index ==
		{run_reg[1:0], run_reg[3:2], run_reg[5:4], run_reg[7:6]}; endproperty
	property p_idle; !result_strobe |-> result_index == 8'h00; endproperty
	property p_gap; $rose(result_strobe) && res_seen_reg |->
		low_reg == 16'd512; endproperty
	property p_ms; mode_sample_strobe && ms_seen_reg |-> gap_reg == 10'd767;
	endproperty
	a_nob: assert property (p_nob) else $error("port B write");
	a_ena: assert property (p_ena) else $error("enable mismatch");
	a_one: assert property (p_one) else $error("both banks written");
	a_pace: assert property (p_pace) else $error("write too soon");
	a_swap: assert property (p_swap) else $error("bank select glitch");
	a_run: assert property (p_run) else $error("strobe length");
	a_idx: assert property (p_idx) else $error("bad index");
	a_idle: assert property (p_idle) else $error("index while idle");
	a_gap: assert property (p_gap) else $error("frame spacing");
	a_ms: assert property (p_ms) else $error("mode strobe spacing");
	c_res: cover property ($rose(result_strobe));
	c_ms: cover property (mode_sample_strobe && ms_seen_reg);
	c_swap: cover property ($changed(bank_select));
endmodule : ppf_chk

// ==== verif/tb_ping_pong_fft_memory_control.sv ====
// Testbench joining the core and the host over one link.
`timescale 1ns/1ps
module tb_ping_pong_fft_memory_control;
	import ppf_pkg::*;
	logic clk = 1'b0;
	logic nrst;
	logic user_load = 1'b0;
	logic user_start = 1'b0;
	logic user_dir = 1'b0;
	ppf_word_t user_re = 16'h0000;
	logic busy, dir_act, scl_act;
	logic fd;
	int err_count = 0, checks = 0, n0 = 0, n1 = 0, ns = 0, nd = 0;
	int i, a0, as, ad, b;
	ppf_addr_t cap [256];
	ppf_addr_t rows [6][2] = '{'{8'h00, 8'h00}, '{8'h01, 8'h40},
		'{8'h02, 8'h80}, '{8'h04, 8'h10}, '{8'h1B, 8'hE4}, '{8'hFF, 8'hFF}};
	ppf_if u_ppf_if ();
	ppf_core u_ppf_core (.clk(clk), .nrst(nrst), .link(u_ppf_if.core),
		.busy(busy), .direction_active(dir_act), .scale_active(scl_act),
		.result_digit());
	ppf_host u_ppf_host (.clk(clk), .nrst(nrst), .link(u_ppf_if.host),
		.user_load(user_load), .user_start(user_start),
		.user_direction(user_dir), .user_scale(user_dir), .user_re(user_re),
		.user_im(~user_re), .result_frame_done(fd));
	ppf_chk u_chk (.clk(clk), .nrst(nrst),
		.mode_sample_strobe(u_ppf_if.mode_sample_strobe),
		.bank_select(u_ppf_if.bank_select),
		.bank0_porta_write_enable(u_ppf_if.bank0_porta_write_enable),
		.bank1_porta_write_enable(u_ppf_if.bank1_porta_write_enable),
		.bank0_portb_write_enable(u_ppf_if.bank0_portb_write_enable),
		.bank1_portb_write_enable(u_ppf_if.bank1_portb_write_enable),
		.bank0_porta_enable(u_ppf_if.bank0_porta_enable),
		.bank1_porta_enable(u_ppf_if.bank1_porta_enable),
		.result_index(u_ppf_if.result_index),
		.result_strobe(u_ppf_if.result_strobe));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		n0 <= n0 + int'(u_ppf_if.bank0_porta_write_enable);
		n1 <= n1 + int'(u_ppf_if.bank1_porta_write_enable);
		ns <= ns + int'(u_ppf_if.result_strobe);
		nd <= nd + int'(fd);
		user_re <= user_re + 16'h0001;
	end
	////////////////////////////////////////////////////////////////////////
	task conclude;
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %h %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle request on load or start, lowered by the next edge.
	task pulse(input logic is_start);
		if (is_start) user_start <= 1'b1;
		else user_load <= 1'b1;
		@(posedge clk);
		user_start <= 1'b0;
		user_load <= 1'b0;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk(busy, 1'b0);
		chk(u_ppf_if.result_strobe, 1'b0);
		pulse(1'b0);
		repeat (300) @(posedge clk);
		chk(16'(n0), 16'd256);
		chk(16'(n1), 16'd0);
		user_dir <= 1'b1;
		pulse(1'b1);
		repeat (3) @(posedge clk);
		user_dir <= 1'b0;
		repeat (100) @(posedge clk);
		chk({dir_act, scl_act}, 2'b11);
		for (i = 0; i < 2000 && u_ppf_if.result_strobe !== 1'b1; i++)
			@(posedge clk);
		// A missing frame counts once; the bounded steps below still end.
		if (i >= 2000) err_count++;
		for (i = 0; i < 256; i++) begin
			cap[i] = u_ppf_if.result_index;
			chk(u_ppf_if.result_strobe, 1'b1);
			chk(u_ppf_if.result_sample_bus_im,
				~u_ppf_if.result_sample_bus_re);
			@(posedge clk);
		end
		// Sparse rows keep the table short; the checker sees every index.
		for (i = 0; i < 6; i++) chk(cap[rows[i][0]], rows[i][1]);
		chk({dir_act, scl_act}, 2'b00);
		b = int'(u_ppf_if.bank_select);
		repeat (768) @(posedge clk);
		chk(u_ppf_if.bank_select, 16'(b == 0));
		pulse(1'b0);
		a0 = n0 + n1;
		as = ns;
		ad = nd;
		repeat (1536) @(posedge clk);
		chk(16'(n0 + n1 - a0), 16'd512);
		chk(16'(ns - as), 16'd512);
		chk(16'(nd - ad), 16'd2);
		chk(busy, 1'b1);
		conclude();
	end
endmodule : tb_ping_pong_fft_memory_control
